//--- hdl/smbus_master_transfer_sequencer.sv
// Two-wire bus master transfer sequencer: software side on mclk_i,
// bit engine on link_clk_i, toggle handshakes between the two.
// Assumes open-drain pads outside: an enable high pulls the wire low.
// How it works
// - mode is always one of master tx, master rx, slave tx, slave rx.
// - master mode starts with START, ends on arbitration loss or STOP.
// - an interrupt is raised for every byte frame, after its ack or, in rx with hw ack off, before it; at once on arbitration loss.
// - receiving: interrupt before ack with hw ack off, after with it on.
// - transmitting: interrupt after the ack cycle, or at once on arbitration loss.
// - write: START, address byte with direction 0, then data bytes.
// - stop request makes a STOP, ends the transfer, leaves master mode.
// - no data write after a master-tx interrupt switches to master rx.
// - read: address with direction 1, master clocks, slave returns data.
// - hw ack off: ack request flag set, interrupt, wait for software ack.
// - hw ack on: drive preset ack or nack, then post the interrupt.
// - ack control 1 sends ack, 0 sends nack.
// - data write while active master rx switches to master tx.
`timescale 1ns/10ps
module smbus_master_transfer_sequencer
  import smbus_seq_pkg::*;
#(
  parameter int QTR_CYC = QTR_CYC_DEF
) (
  // clocks and reset
  input wire logic mclk_i,
  input wire logic link_clk_i,
  input wire logic reset_n_i,
  // software controls
  input wire logic start_req_i,
  input wire logic [ADDR_W-1:0] slave_addr_i,
  input wire logic dir_read_i,
  input wire logic data_wr_i,
  input wire logic [BYTE_W-1:0] data_i,
  input wire logic stop_request_i,
  input wire logic ack_ctrl_i,
  input wire logic hw_ack_en_i,
  input wire logic irq_clear_i,
  // software status
  output logic byte_irq_o,
  output logic ack_request_flag_o,
  output logic [BYTE_W-1:0] serial_data_register_o,
  output logic rx_ack_o,
  output logic arb_lost_o,
  output mode_e mode_o,
  output logic master_o,
  output logic busy_o,
  // bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  localparam logic [CNT_W-1:0] QTR_M1 = CNT_W'(QTR_CYC - 1);

  // ****************************************************************
  // software side (mclk)
  // ****************************************************************
  logic stop_r, stop_nxt, datw_r, datw_nxt, irq_r, irq_nxt, req_r, req_nxt;
  logic rack_r, rack_nxt, arb_r, arb_nxt, busy_r, busy_nxt;
  logic [BYTE_W-1:0] dat_r, dat_nxt, rxd_r, rxd_nxt, cbyte_r, cbyte_nxt;
  mode_e mode_r, mode_nxt;
  op_e cop_r, cop_nxt;
  logic ctgl_r, ctgl_nxt, cack_r, cack_nxt, chw_r, chw_nxt;
  logic ev_s1_r, ev_s2_r, ev_seen_r, ev_new;
  logic go_start, go_resume;
  // link-side event payload, held stable while its toggle crosses
  logic etgl_r, etgl_nxt, eirq_r, eirq_nxt, ereq_r, ereq_nxt;
  logic earb_r, earb_nxt, erack_r, erack_nxt;
  logic [BYTE_W-1:0] erx_r, erx_nxt;
  mode_e emode_r, emode_nxt, bmode_r, bmode_nxt;

  assign master_o = (mode_r == MODE_MT) || (mode_r == MODE_MR);
  assign go_start = start_req_i && !busy_r && !master_o;
  assign go_resume = irq_clear_i && irq_r && master_o && !busy_r;

  // next values; only one command may be in flight (busy_r)
  always_comb begin
    ev_new = ev_s2_r ^ ev_seen_r;
    stop_nxt = (stop_r | stop_request_i) & (master_o | busy_r);
    dat_nxt = data_wr_i ? data_i : dat_r;
    datw_nxt = datw_r | data_wr_i;
    irq_nxt = irq_r & ~irq_clear_i;
    req_nxt = req_r & ~irq_clear_i;
    arb_nxt = arb_r & ~irq_clear_i;
    rack_nxt = rack_r;
    rxd_nxt = rxd_r;
    mode_nxt = mode_r;
    busy_nxt = busy_r;
    ctgl_nxt = ctgl_r;
    cop_nxt = cop_r;
    cbyte_nxt = cbyte_r;
    cack_nxt = cack_r;
    chw_nxt = chw_r;
    if (go_start) begin
      ctgl_nxt = ~ctgl_r;
      busy_nxt = 1'b1;
      cop_nxt = OP_START;
      cbyte_nxt = {slave_addr_i, dir_read_i};
      datw_nxt = data_wr_i;  // data left from an earlier transfer is dropped
    end else if (go_resume) begin
      ctgl_nxt = ~ctgl_r;
      busy_nxt = 1'b1;
      cack_nxt = ack_ctrl_i;  // ack for a byte held in ST_RACKW, else preset ack for the next byte
      chw_nxt = hw_ack_en_i;
      if (stop_r) begin
        cop_nxt = OP_STOP;
        stop_nxt = stop_request_i;
      end else if (datw_r) begin
        cop_nxt = OP_WRITE;
        cbyte_nxt = dat_r;
        datw_nxt = data_wr_i;
      end else begin
        cop_nxt = OP_READ;  // no data written: become receiver
      end
    end
    // a new event wins over a same-cycle clear
    if (ev_new) begin
      busy_nxt = 1'b0;
      mode_nxt = emode_r;
      rxd_nxt = erx_r;
      rack_nxt = erack_r;
      if (eirq_r) begin
        irq_nxt = 1'b1;
        req_nxt = ereq_r;
        arb_nxt = earb_r;
      end
    end
  end

  // registers of the software side
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {stop_r, datw_r, irq_r, req_r, rack_r, arb_r, busy_r} <= '0;
      {ctgl_r, cack_r, chw_r, ev_s1_r, ev_s2_r, ev_seen_r} <= '0;
      dat_r <= '0;
      rxd_r <= '0;
      cbyte_r <= '0;
      cop_r <= OP_START;
      mode_r <= MODE_SR;
    end else begin
      ev_s1_r <= etgl_r;
      ev_s2_r <= ev_s1_r;
      ev_seen_r <= ev_s2_r;
      {stop_r, datw_r, irq_r, req_r} <= {stop_nxt, datw_nxt, irq_nxt, req_nxt};
      {rack_r, arb_r, busy_r} <= {rack_nxt, arb_nxt, busy_nxt};
      {ctgl_r, cack_r, chw_r} <= {ctgl_nxt, cack_nxt, chw_nxt};
      dat_r <= dat_nxt;
      rxd_r <= rxd_nxt;
      cbyte_r <= cbyte_nxt;
      cop_r <= cop_nxt;
      mode_r <= mode_nxt;
    end
  end

  assign byte_irq_o = irq_r;
  assign ack_request_flag_o = req_r;
  assign serial_data_register_o = rxd_r;
  assign rx_ack_o = rack_r;
  assign arb_lost_o = arb_r;
  assign mode_o = mode_r;
  assign busy_o = busy_r;

  // ****************************************************************
  // bit engine (link clock)
  // ****************************************************************
  state_e st_r, st_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [BYTE_W-1:0] sh_r, sh_nxt;
  logic scl_oe_r, scl_nxt, sda_oe_r, sda_nxt, tx_r, tx_nxt;
  logic sda_pin_r;  // sda pin lags the engine by one link cycle
  logic ack_r, ack_nxt, hw_r, hw_nxt;
  logic c_s1_r, c_s2_r, c_seen_r, cmd_new;
  logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r;
  logic tick, post, post_irq, post_req, arb, do_op;

  // next values; commands read cbyte_r/cop_r only after the toggle lands
  always_comb begin
    cmd_new = c_s2_r ^ c_seen_r;
    tick = (cnt_r == '0);
    st_nxt = st_r;
    ph_nxt = ph_r;
    cnt_nxt = tick ? cnt_r : cnt_r - 1'b1;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    {scl_nxt, sda_nxt, tx_nxt, ack_nxt, hw_nxt} = {scl_oe_r, sda_oe_r, tx_r, ack_r, hw_r};
    bmode_nxt = bmode_r;
    {post, post_irq, post_req, arb, do_op} = '0;
    case (st_r)
      ST_IDLE: begin
        if (cmd_new && cop_r == OP_START) begin
          sda_nxt = 1'b1;  // sda falls while scl is high
          sh_nxt = cbyte_r;
          tx_nxt = 1'b1;
          bmode_nxt = MODE_MT;
          st_nxt = ST_START;
          cnt_nxt = QTR_M1;
        end
      end
      ST_START: begin
        if (tick) begin
          scl_nxt = 1'b1;
          sda_nxt = ~sh_r[BYTE_W-1];  // msb first
          st_nxt = ST_BITS;
          ph_nxt = PH_LOW;
          bit_nxt = BIT_MSB;
          cnt_nxt = QTR_M1;
        end
      end
      ST_BITS, ST_ACK, ST_STOP: begin
        case (ph_r)
          PH_LOW: begin
            if (tick) begin
              scl_nxt = 1'b0;
              ph_nxt = PH_HIGH;
              cnt_nxt = QTR_M1;
            end
          end
          PH_HIGH: begin
            // wait out a slave stretching the clock
            if (tick && scl_s2_r) begin
              ph_nxt = PH_TAIL;
              cnt_nxt = QTR_M1;
              if (st_r == ST_BITS) begin
                arb = tx_r && sh_r[BYTE_W-1] && !sda_s2_r;
                sh_nxt = {sh_r[BYTE_W-2:0], sda_s2_r};
              end else if (st_r == ST_ACK && tx_r) begin
                ack_nxt = ~sda_s2_r;  // slave ack seen
              end
            end
          end
          default: begin
            if (tick) begin
              scl_nxt = 1'b1;
              ph_nxt = PH_LOW;
              cnt_nxt = QTR_M1;
              if (st_r == ST_STOP) begin
                scl_nxt = 1'b0;
                sda_nxt = 1'b0;  // sda rises while scl high
                st_nxt = ST_IDLE;
                bmode_nxt = MODE_SR;
                post = 1'b1;
              end else if (st_r == ST_BITS && bit_r != '0) begin
                bit_nxt = bit_r - 1'b1;
                sda_nxt = tx_r & ~sh_r[BYTE_W-1];
              end else if (st_r == ST_BITS) begin
                st_nxt = ST_ACK;
                sda_nxt = ~tx_r & ack_r;  // 1 acks, 0 nacks
                if (!tx_r && !hw_r) begin
                  sda_nxt = 1'b0;
                  st_nxt = ST_RACKW;  // interrupt before the ack
                  post = 1'b1;
                  post_irq = 1'b1;
                  post_req = 1'b1;
                end
              end else if (tx_r || hw_r) begin
                sda_nxt = 1'b0;
                st_nxt = ST_HOLD;  // interrupt after the ack
                post = 1'b1;
                post_irq = 1'b1;
              end else begin
                do_op = 1'b1;
              end
            end
          end
        endcase
      end
      ST_RACKW: begin
        if (cmd_new) begin
          ack_nxt = cack_r;  // software-supplied ack
          sda_nxt = cack_r;
          st_nxt = ST_ACK;
          ph_nxt = PH_LOW;
          cnt_nxt = QTR_M1;
        end
      end
      ST_HOLD: do_op = cmd_new;
      default: st_nxt = ST_IDLE;
    endcase
    // scl is held low in ST_HOLD until the next command
    if (do_op) begin
      cnt_nxt = QTR_M1;
      ph_nxt = PH_LOW;
      bit_nxt = BIT_MSB;
      case (cop_r)
        OP_WRITE: begin
          st_nxt = ST_BITS;
          tx_nxt = 1'b1;
          sh_nxt = cbyte_r;
          sda_nxt = ~cbyte_r[BYTE_W-1];
          bmode_nxt = MODE_MT;
        end
        OP_READ: begin
          st_nxt = ST_BITS;
          tx_nxt = 1'b0;
          sda_nxt = 1'b0;
          hw_nxt = chw_r;
          ack_nxt = cack_r;
          bmode_nxt = MODE_MR;
        end
        OP_STOP: begin
          st_nxt = ST_STOP;
          sda_nxt = 1'b1;
        end
        default: st_nxt = ST_HOLD;  // repeated start is not offered
      endcase
    end
    if (arb) begin
      {scl_nxt, sda_nxt} = 2'b00;
      st_nxt = ST_IDLE;
      bmode_nxt = MODE_SR;  // loss ends master mode
      post = 1'b1;
      post_irq = 1'b1;
    end
    etgl_nxt = etgl_r ^ post;
    erx_nxt = post ? sh_nxt : erx_r;
    eirq_nxt = post ? post_irq : eirq_r;
    ereq_nxt = post ? post_req : ereq_r;
    earb_nxt = post ? arb : earb_r;
    erack_nxt = post ? ack_nxt : erack_r;
    emode_nxt = post ? bmode_nxt : emode_r;
  end

  // registers of the bit engine; pins pass two flip-flops first
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {c_s1_r, c_s2_r, c_seen_r, scl_oe_r, sda_oe_r, tx_r, ack_r, hw_r} <= '0;
      {scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r} <= 4'hf;
      {etgl_r, eirq_r, ereq_r, earb_r, erack_r} <= '0;
      st_r <= ST_IDLE;
      sda_pin_r <= 1'b0;
      ph_r <= PH_LOW;
      cnt_r <= '0;
      bit_r <= '0;
      sh_r <= '0;
      erx_r <= '0;
      bmode_r <= MODE_SR;
      emode_r <= MODE_SR;
    end else begin
      {c_s1_r, c_s2_r, c_seen_r} <= {ctgl_r, c_s1_r, c_s2_r};
      {scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r} <= {scl_i, scl_s1_r, sda_i, sda_s1_r};
      {scl_oe_r, sda_oe_r, tx_r, ack_r, hw_r} <= {scl_nxt, sda_nxt, tx_nxt, ack_nxt, hw_nxt};
      {etgl_r, eirq_r, ereq_r, earb_r, erack_r} <=
        {etgl_nxt, eirq_nxt, ereq_nxt, earb_nxt, erack_nxt};
      st_r <= st_nxt;
      sda_pin_r <= sda_oe_r;
      ph_r <= ph_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      erx_r <= erx_nxt;
      bmode_r <= bmode_nxt;
      emode_r <= emode_nxt;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_oe_r;
  // sda moves one link cycle after scl falls: a hold time, so no data edge
  // can pass for start or stop; limitation: QTR_CYC must be 2 or more
  assign sda_oe_o = sda_pin_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  start_cond_a: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    st_r == ST_IDLE && cmd_new && cop_r == OP_START |=> sda_oe_r && !scl_oe_r
      && bmode_r == MODE_MT) else $error("start not driven");
  arb_exit_a: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    arb |=> st_r == ST_IDLE && bmode_r == MODE_SR && !scl_oe_r && earb_r)
    else $error("arbitration loss kept master");
  irq_set_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ev_new && eirq_r |=> irq_r) else $error("byte interrupt lost");
  sw_ack_wait_a: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    post && post_req |=> st_r == ST_RACKW && scl_oe_r && ereq_r)
    else $error("no wait before ack");
  tx_after_ack_a: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    post_irq && tx_r && !arb |-> st_r == ST_ACK && ph_r == PH_TAIL)
    else $error("tx interrupt not after ack");
  addr_byte_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    go_start |=> cop_r == OP_START && cbyte_r[0] == $past(dir_read_i)
      && cbyte_r[BYTE_W-1:1] == $past(slave_addr_i)) else $error("bad address byte");
  stop_cmd_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    go_resume && stop_r && !stop_request_i |=> cop_r == OP_STOP && !stop_r)
    else $error("stop not issued");
  stop_leave_a: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    st_r == ST_STOP ##1 st_r == ST_IDLE |-> bmode_r == MODE_SR && !sda_oe_r)
    else $error("stop kept master");
  rd_switch_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    go_resume && !stop_r && !datw_r |=> cop_r == OP_READ) else $error("no rx switch");
  wr_switch_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    go_resume && !stop_r && datw_r |=> cop_r == OP_WRITE && cbyte_r == $past(dat_r))
    else $error("no tx switch");
  ack_drive_a: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    st_r == ST_ACK && !tx_r && ph_r == PH_HIGH |-> sda_oe_r == ack_r)
    else $error("wrong ack level");

  write_seen_c: cover property (@(posedge link_clk_i) disable iff (!reset_n_i)
    post_irq && tx_r && !arb);
  read_hw_c: cover property (@(posedge link_clk_i) disable iff (!reset_n_i)
    post_irq && !tx_r && hw_r);
  read_sw_c: cover property (@(posedge link_clk_i) disable iff (!reset_n_i) post_req);
  arb_loss_c: cover property (@(posedge link_clk_i) disable iff (!reset_n_i) arb);
endmodule : smbus_master_transfer_sequencer

//--- hdl/smbus_seq_pkg.sv
// ****************************************************************
// smbus_seq_pkg: constants and types of the two-wire transfer sequencer
// ****************************************************************
// assumes: shared by the sequencer and its testbench; no timescale needed
package smbus_seq_pkg;
  // operating modes, exactly one active at a time
  typedef enum logic [1:0] {MODE_MT, MODE_MR, MODE_ST, MODE_SR} mode_e;
  // commands passed from the software side to the link side
  typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} op_e;
  // link-side sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_BITS, ST_ACK, ST_RACKW, ST_HOLD, ST_STOP
  } state_e;
  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 8;
  localparam int QTR_CYC_DEF = 4;   // link cycles per phase of a bit
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [2:0] BIT_MSB = 3'h7;
  // bit phases: scl low, scl high (sample), scl high tail
  localparam logic [1:0] PH_LOW = 2'h0;
  localparam logic [1:0] PH_HIGH = 2'h1;
  localparam logic [1:0] PH_TAIL = 2'h2;
endpackage : smbus_seq_pkg

//--- dv/smbus_slave_model.sv
// slave device model for the two-wire bus: acks every byte it is sent and
// returns read data; it may stretch the clock before each ack slot.
// assumes: open-drain wires resolved with pull-ups by the bench.
`timescale 1ns/10ps
module smbus_slave_model (
  // bus wires
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o,
  // behaviour and observation
  input wire logic stretch_i,
  input wire logic [7:0] rd_data_i,
  output logic [7:0] addr_byte_o,
  output logic [7:0] rx_byte_o,
  output int n_rx_o,
  output logic mack_o,
  output int n_mack_o
);
  logic [3:0] bit_cnt;
  logic [7:0] sh;
  logic [7:0] tx;
  logic active;
  logic first;
  logic reading;
  logic rd_pend;

  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    active = 1'b0;
    n_rx_o = 0;
    n_mack_o = 0;
  end

  // start and stop are sda edges while scl is high
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      active = 1'b1;
      first = 1'b1;
      reading = 1'b0;
      bit_cnt = 4'h0;
    end
  end
  always @(posedge sda_i) begin
    if (scl_i === 1'b1) begin
      active = 1'b0;
      sda_oe_o = 1'b0;
    end
  end

  // sample data and the master's ack while scl is high
  always @(posedge scl_i) begin
    if (active) begin
      if (bit_cnt < 4'h8) begin
        sh = {sh[6:0], sda_i};
      end else if (reading) begin
        mack_o = !sda_i;
        n_mack_o++;
        rd_pend = !sda_i; // a nack ends the read
      end
      bit_cnt++;
    end
  end

  // drive only while scl is low, so no data edge can look like start or stop
  always @(negedge scl_i) begin
    if (active) begin
      if (bit_cnt == 4'h8) begin
        if (first) begin
          addr_byte_o = sh;
          rd_pend = sh[0];
          tx = rd_data_i;
        end else if (!reading) begin
          rx_byte_o = sh;
          n_rx_o++;
        end else begin
          tx = tx + 8'h11;
        end
        sda_oe_o = !reading;
        first = 1'b0;
        if (stretch_i) begin
          scl_oe_o = 1'b1; // slow answer: hold the clock low before the ack slot
          #150;
          scl_oe_o = 1'b0;
        end
      end else if (bit_cnt == 4'h9) begin
        bit_cnt = 4'h0;
        reading = rd_pend;
        sda_oe_o = reading & !tx[7];
      end else if (reading) begin
        sda_oe_o = !tx[3'(4'h7 - bit_cnt)];
      end
    end
  end
endmodule : smbus_slave_model

//--- dv/smbus_master_transfer_sequencer_test.sv
// testbench of the transfer sequencer: software calls through its ports,
// a slave model on the open-drain wires.
// assumes: pull-ups on both wires; QTR_CYC shortened to 2 for run time.
`timescale 1ns/10ps
module smbus_master_transfer_sequencer_test import smbus_seq_pkg::*; ;
  logic mclk_i, link_clk_i, reset_n_i, start_req_i, dir_read_i, data_wr_i;
  logic stop_request_i, ack_ctrl_i, hw_ack_en_i, irq_clear_i, stretch;
  logic [6:0] slave_addr_i;
  logic [7:0] data_i, rd_data, wb;
  logic byte_irq_o, ack_request_flag_o, rx_ack_o, arb_lost_o, master_o, busy_o;
  logic scl_oe_o, sda_oe_o, s_scl_oe, s_sda_oe, mack;
  logic [7:0] serial_data_register_o, addr_byte, rx_byte;
  mode_e mode_o;
  wire logic scl, sda;
  int n_rx, n_mack, m0, n_fail, check_count;

  // ****************************************************************
  // clocks, wires, instances
  // ****************************************************************
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #1.7;
    forever #3 link_clk_i = ~link_clk_i;
  end
  // either party pulling low wins; released wires float high
  assign scl = !(scl_oe_o | s_scl_oe);
  assign sda = !(sda_oe_o | s_sda_oe);

  smbus_master_transfer_sequencer #(.QTR_CYC(2)) dut (
    .mclk_i(mclk_i), .link_clk_i(link_clk_i), .reset_n_i(reset_n_i),
    .start_req_i(start_req_i), .slave_addr_i(slave_addr_i), .dir_read_i(dir_read_i),
    .data_wr_i(data_wr_i), .data_i(data_i), .stop_request_i(stop_request_i),
    .ack_ctrl_i(ack_ctrl_i), .hw_ack_en_i(hw_ack_en_i), .irq_clear_i(irq_clear_i),
    .byte_irq_o(byte_irq_o), .ack_request_flag_o(ack_request_flag_o),
    .serial_data_register_o(serial_data_register_o), .rx_ack_o(rx_ack_o),
    .arb_lost_o(arb_lost_o), .mode_o(mode_o), .master_o(master_o), .busy_o(busy_o),
    .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe_o));

  smbus_slave_model slave (
    .scl_i(scl), .sda_i(sda), .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe),
    .stretch_i(stretch), .rd_data_i(rd_data), .addr_byte_o(addr_byte),
    .rx_byte_o(rx_byte), .n_rx_o(n_rx), .mack_o(mack), .n_mack_o(n_mack));

  // ****************************************************************
  // compare and access tasks
  // ****************************************************************
  task automatic fail_msg(input string what);
    n_fail++;
    $display("mismatch at %0t: %s", $time, what);
  endtask : fail_msg
  task automatic check_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) fail_msg(what);
  endtask : check_bit
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) fail_msg(what);
  endtask : check_byte
  task automatic check_mode(input mode_e got, input mode_e exp, input string what);
    check_count++;
    if (got !== exp) fail_msg(what);
  endtask : check_mode
  task automatic check_cnt(input int got, input int exp, input string what);
    check_count++;
    if (got != exp) fail_msg(what);
  endtask : check_cnt

  task automatic start_xfer(input logic [6:0] a, input logic d);
    @(posedge mclk_i);
    start_req_i <= 1'b1;
    slave_addr_i <= a;
    dir_read_i <= d;
    @(posedge mclk_i);
    start_req_i <= 1'b0;
  endtask : start_xfer
  // software answer to a byte interrupt: optional data and stop, then clear
  task automatic resume(input logic wr, input logic [7:0] d, input logic stp, input logic ack);
    @(posedge mclk_i);
    data_wr_i <= wr;
    data_i <= d;
    stop_request_i <= stp;
    ack_ctrl_i <= ack;
    @(posedge mclk_i);
    data_wr_i <= 1'b0;
    stop_request_i <= 1'b0;
    irq_clear_i <= 1'b1;
    @(posedge mclk_i);
    irq_clear_i <= 1'b0;
  endtask : resume
  task automatic wait_irq();
    for (int i = 0; i < 3000; i++) begin
      @(negedge mclk_i);
      if (byte_irq_o === 1'b1) break;
    end
    check_bit(byte_irq_o, 1'b1, "byte interrupt");
  endtask : wait_irq
  task automatic wait_idle();
    for (int i = 0; i < 3000; i++) begin
      @(negedge mclk_i);
      if (master_o === 1'b0 && busy_o === 1'b0) break;
    end
    check_bit(master_o, 1'b0, "master left");
    check_bit(busy_o, 1'b0, "busy after stop");
    check_bit(sda_oe_o, 1'b0, "sda released after stop");
    check_mode(mode_o, MODE_SR, "idle mode after stop");
  endtask : wait_idle
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // watchdog: the tests need some 6 us, so 300 us means a hang
  initial begin
    #300000;
    fail_msg("watchdog expired");
    report_and_stop();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    {reset_n_i, start_req_i, dir_read_i, data_wr_i, stop_request_i} = 5'h00;
    {ack_ctrl_i, hw_ack_en_i, irq_clear_i, stretch} = 4'h0;
    slave_addr_i = 7'h00;
    data_i = 8'h00;
    rd_data = 8'hc3;
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    check_mode(mode_o, MODE_SR, "mode after reset");
    check_bit(master_o, 1'b0, "master after reset");
    // write of two data bytes, then stop
    start_xfer(7'h5a, 1'b0);
    wait_irq();
    check_byte(addr_byte, 8'hb4, "write address byte");
    check_mode(mode_o, MODE_MT, "mode after start");
    check_bit(rx_ack_o, 1'b1, "address ack before irq");
    for (int i = 0; i < 2; i++) begin
      wb = 8'h81 ^ {8{i[0]}};
      resume(1'b1, wb, 1'b0, 1'b1);
      wait_irq();
      check_byte(rx_byte, wb, "written byte");
      check_cnt(n_rx, i + 1, "byte acked before irq");
      check_mode(mode_o, MODE_MT, "write stays tx");
    end
    resume(1'b0, 8'h00, 1'b1, 1'b1);
    wait_idle();
    $display("test write done");
    // read with software ack, then a data write turns to tx
    start_xfer(7'h5a, 1'b1);
    wait_irq();
    check_byte(addr_byte, 8'hb5, "read address byte");
    m0 = n_mack;
    resume(1'b0, 8'h00, 1'b0, 1'b1);
    wait_irq();
    check_mode(mode_o, MODE_MR, "no data write gives rx");
    check_bit(ack_request_flag_o, 1'b1, "ack request raised");
    check_byte(serial_data_register_o, 8'hc3, "first read byte");
    check_cnt(n_mack, m0, "irq before ack");
    resume(1'b0, 8'h00, 1'b0, 1'b1);
    wait_irq();
    check_bit(mack, 1'b1, "software ack sent");
    check_byte(serial_data_register_o, 8'hd4, "second read byte");
    resume(1'b1, 8'h3c, 1'b0, 1'b0);
    wait_irq();
    check_bit(mack, 1'b0, "software nack sent");
    check_mode(mode_o, MODE_MT, "data write gives tx");
    check_byte(rx_byte, 8'h3c, "byte after turn");
    check_bit(arb_lost_o, 1'b0, "no arbitration loss");
    resume(1'b0, 8'h00, 1'b1, 1'b0);
    wait_idle();
    $display("test read software ack done");
    // read with hardware ack and a stretching slave
    @(posedge mclk_i);
    hw_ack_en_i <= 1'b1;
    stretch <= 1'b1;
    start_xfer(7'h5a, 1'b1);
    wait_irq();
    m0 = n_mack;
    resume(1'b0, 8'h00, 1'b0, 1'b1);
    wait_irq();
    check_cnt(n_mack, m0 + 1, "irq after ack");
    check_bit(mack, 1'b1, "preset ack sent");
    check_bit(ack_request_flag_o, 1'b0, "no ack request");
    check_byte(serial_data_register_o, 8'hc3, "stretched read byte");
    resume(1'b0, 8'h00, 1'b0, 1'b0);
    wait_irq();
    check_bit(mack, 1'b0, "preset nack sent");
    check_mode(mode_o, MODE_MR, "read stays rx");
    resume(1'b0, 8'h00, 1'b1, 1'b0);
    wait_idle();
    $display("test read hardware ack done");
    report_and_stop();
  end
endmodule : smbus_master_transfer_sequencer_test
